// *** verilog/edp_pkg.sv ***
// Shared constants, register map and types of the external data access block
package edp_pkg;

  // Register indices; byte address is four times the index
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_PTR_SEL = 10'h086;
  localparam logic [IDX_W-1:0] IDX_CLK_CTRL = 10'h08e;
  localparam logic [IDX_W-1:0] IDX_CMD = 10'h090;
  localparam logic [IDX_W-1:0] IDX_INDIRECT = 10'h091;
  localparam logic [IDX_W-1:0] IDX_PORT2 = 10'h092;
  localparam logic [IDX_W-1:0] IDX_DP0 = 10'h093;
  localparam logic [IDX_W-1:0] IDX_DP1 = 10'h094;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h095;
  localparam int BYTE_LSB = 2;

  // Field positions
  localparam int PTR_SEL_BIT = 0;
  localparam int STRETCH_LSB = 0;
  localparam int STRETCH_W = 3;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 3;
  localparam int CMD_WR_BIT = 3;
  localparam int CMD_LEN_LSB = 4;
  localparam int CMD_LEN_W = 3;
  localparam int CMD_DATA_LSB = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_HOLD_BIT = 1;
  localparam int STAT_RDATA_LSB = 8;
  localparam int STAT_MC_LSB = 16;

  // Reset values
  localparam logic PTR_SEL_RESET = 1'b0;
  localparam logic [STRETCH_W-1:0] STRETCH_RESET = 3'h1;
  localparam logic [15:0] DP_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Command operations
  localparam logic [CMD_OP_W-1:0] OP_INSTR = 3'h0;
  localparam logic [CMD_OP_W-1:0] OP_MOVE_IND = 3'h1;
  localparam logic [CMD_OP_W-1:0] OP_MOVE_PTR = 3'h2;
  localparam logic [CMD_OP_W-1:0] OP_INC_SEL = 3'h3;
  localparam logic [CMD_OP_W-1:0] OP_INC_PTR = 3'h4;

  // Timing counts
  localparam int STATE_TICKS = 2;
  localparam logic [3:0] MIN_INSTR_MC = 4'h1;
  localparam logic [3:0] MAX_INSTR_MC = 4'h5;
  localparam logic [7:0] SHORT_STROBE_START = 8'h02;
  localparam logic [7:0] SHORT_STROBE_TICKS = 8'h04;
  localparam logic [7:0] LONG_STROBE_START = 8'h04;
  localparam logic [7:0] TICKS_PER_MC = 8'h08;

  typedef enum logic [1:0] {state_c1, state_c2, state_c3, state_c4} edp_state_t;
  typedef enum logic [2:0] {ST_IDLE, ST_INSTR, ST_FETCH, ST_ACCESS, ST_STRETCH} edp_fsm_t;

endpackage : edp_pkg

// *** verilog/edp_timing_if.sv ***
// Machine cycle timing carried from the sequencer to the core
`timescale 1ns/10ps
interface edp_timing_if;
  import edp_pkg::*;
  edp_state_t state;
  logic late;
  logic mc_last;
  modport seq (output state, output late, output mc_last);
  modport core (input state, input late, input mc_last);
endinterface : edp_timing_if

// *** verilog/edp_cycle_seq.sv ***
// Four-state machine cycle sequencer with early and late half per state
`timescale 1ns/10ps
module edp_cycle_seq
  import edp_pkg::*;
(
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Timing out
  edp_timing_if.seq tim
);

  localparam int SUB_W = (STATE_TICKS > 1) ? $clog2(STATE_TICKS) : 1;
  localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(STATE_TICKS - 1);

  edp_state_t state;
  edp_state_t next_state;
  logic [SUB_W-1:0] sub;
  logic [SUB_W-1:0] next_sub;
  wire sub_last = (sub == SUB_LAST);

  function automatic edp_state_t step_state(input edp_state_t s);
    case (s)
      state_c1: step_state = state_c2;
      state_c2: step_state = state_c3;
      state_c3: step_state = state_c4;
      default: step_state = state_c1;
    endcase
  endfunction : step_state

  // Fixed order, four states to a machine cycle
  assign next_state = sub_last ? step_state(state) : state;
  // Two halves stand for the two clock edges of each state
  assign next_sub = sub_last ? '0 : SUB_W'(sub + 1'b1);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state <= state_c1;
      sub <= '0;
    end
    else if (ce_i)
    begin
      state <= next_state;
      sub <= next_sub;
    end
  end

  assign tim.state = state;
  assign tim.late = sub_last;
  assign tim.mc_last = sub_last && (state == state_c4);

endmodule : edp_cycle_seq

// *** verilog/edp_xdata_core.sv ***
// External data move timing, dual data pointers and AHB-Lite register file
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/10ps
module edp_xdata_core
  import edp_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // External data memory pins
  output logic [15:0] ext_addr_o,
  output logic ext_rd_n_o,
  output logic ext_wr_n_o,
  output logic [7:0] ext_data_o,
  output logic ext_data_oe_o,
  input wire logic [7:0] ext_data_i,
  // Core timing status
  output logic [1:0] state_o,
  output logic opcode_fetch_o,
  output logic cpu_hold_o
);

  edp_timing_if tim ();

  edp_cycle_seq u_seq (
    .clk_i (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i (ce_i),
    .tim (tim)
  );

  // Register state
  logic ptr_sel;
  logic [STRETCH_W-1:0] stretch;
  logic [7:0] indirect_register;
  logic [7:0] port2_latch;
  logic [15:0] data_pointer_zero;
  logic [15:0] data_pointer_one;
  logic [31:0] cmd;
  logic cmd_pend;
  logic [7:0] rd_byte;
  logic [3:0] last_mc;

  // Bus state
  logic wr_pend;
  logic [IDX_W-1:0] wr_idx;
  logic rd_pend;
  logic [IDX_W-1:0] rd_idx;

  // Sequencing state
  edp_fsm_t fsm;
  edp_fsm_t next_fsm;
  logic [3:0] mc_cnt;
  logic [3:0] next_mc_cnt;
  logic [7:0] tk;
  logic [7:0] next_tk;
  logic [2:0] run_op;
  logic run_wr;
  logic [3:0] run_len;
  logic [7:0] run_data;
  logic [STRETCH_W-1:0] run_stretch;

  // Pin sampling, three stages
  logic [7:0] din_s1;
  logic [7:0] din_s2;
  logic [7:0] din_s3;
  logic [7:0] din_ok;

  function automatic logic [3:0] clamp_len(input logic [CMD_LEN_W-1:0] l);
    logic [3:0] w;
    w = {1'b0, l};
    if (w < MIN_INSTR_MC)
      clamp_len = MIN_INSTR_MC;
    else if (w > MAX_INSTR_MC)
      clamp_len = MAX_INSTR_MC;
    else
      clamp_len = w;
  endfunction : clamp_len

  function automatic logic [7:0] strobe_start(input logic [STRETCH_W-1:0] s);
    strobe_start = (s == '0) ? SHORT_STROBE_START : LONG_STROBE_START;
  endfunction : strobe_start

  function automatic logic [7:0] strobe_len(input logic [STRETCH_W-1:0] s);
    strobe_len = (s == '0) ? SHORT_STROBE_TICKS : 8'(TICKS_PER_MC * {5'h00, s});
  endfunction : strobe_len

  // Bus decode
  wire bus_take = hsel_i && htrans_i[1] && hready_i;
  wire [IDX_W-1:0] bus_idx = haddr_i[BYTE_LSB +: IDX_W];
  wire wr_go = wr_pend && ce_i;
  wire wr_cmd = wr_go && (wr_idx == IDX_CMD);
  wire busy = cmd_pend || (fsm != ST_IDLE);
  wire [CMD_OP_W-1:0] wr_op = hwdata_i[CMD_OP_LSB +: CMD_OP_W];
  wire cmd_timed = (wr_op == OP_INSTR) || (wr_op == OP_MOVE_IND) || (wr_op == OP_MOVE_PTR);
  wire cmd_accept = wr_cmd && !busy && cmd_timed;
  wire inc_sel = wr_cmd && (wr_op == OP_INC_SEL);
  wire inc_ptr = wr_cmd && (wr_op == OP_INC_PTR);
  wire start = cmd_pend && (fsm == ST_IDLE) && tim.mc_last;

  // Selected pointer and move address
  wire [15:0] sel_ptr = ptr_sel ? data_pointer_one : data_pointer_zero;
  wire [15:0] ind_addr = {port2_latch, indirect_register};
  wire [15:0] move_addr = (run_op == OP_MOVE_PTR) ? sel_ptr : ind_addr;

  // Strobe window inside access and stretch cycles
  wire [7:0] stb_lo = strobe_start(run_stretch);
  wire [7:0] stb_hi = 8'(stb_lo + strobe_len(run_stretch));
  wire in_move = (fsm == ST_ACCESS) || (fsm == ST_STRETCH);
  wire stb_on = in_move && (tk >= stb_lo) && (tk < stb_hi);
  // Pin sampling lags three stages, so the read byte is taken just past the strobe
  wire rd_take = in_move && (tk == 8'(stb_hi + 8'h01));

  // Read mux
  logic [31:0] rd_val;
  always_comb
  begin
    rd_val = 32'h0000_0000;
    case (rd_idx)
      IDX_PTR_SEL: rd_val[PTR_SEL_BIT] = ptr_sel;
      IDX_CLK_CTRL: rd_val[STRETCH_LSB +: STRETCH_W] = stretch;
      IDX_CMD: rd_val = cmd;
      IDX_INDIRECT: rd_val[7:0] = indirect_register;
      IDX_PORT2: rd_val[7:0] = port2_latch;
      IDX_DP0: rd_val[15:0] = data_pointer_zero;
      IDX_DP1: rd_val[15:0] = data_pointer_one;
      IDX_STATUS:
      begin
        rd_val[STAT_BUSY_BIT] = busy;
        rd_val[STAT_HOLD_BIT] = cpu_hold_o;
        rd_val[STAT_RDATA_LSB +: 8] = rd_byte;
        rd_val[STAT_MC_LSB +: 4] = last_mc;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // AHB-Lite: writes zero-wait, reads take one wait state
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_pend <= 1'b0;
      wr_idx <= '0;
      rd_pend <= 1'b0;
      rd_idx <= '0;
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
    else if (ce_i)
    begin
      wr_pend <= bus_take && hwrite_i;
      wr_idx <= bus_idx;
      rd_pend <= bus_take && !hwrite_i;
      if (bus_take && !hwrite_i)
        rd_idx <= bus_idx;
      hreadyout_o <= !(bus_take && !hwrite_i);
      if (rd_pend)
        hrdata_o <= rd_val;
    end
  end

  // Software-visible registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ptr_sel <= PTR_SEL_RESET;
      stretch <= STRETCH_RESET;
      indirect_register <= BYTE_RESET;
      port2_latch <= BYTE_RESET;
      data_pointer_zero <= DP_RESET;
      data_pointer_one <= DP_RESET;
      cmd <= 32'h0000_0000;
    end
    else if (wr_go)
    begin
      if (wr_idx == IDX_PTR_SEL)
        ptr_sel <= hwdata_i[PTR_SEL_BIT];
      if (inc_sel)
        ptr_sel <= ~ptr_sel;
      if (wr_idx == IDX_CLK_CTRL)
        stretch <= hwdata_i[STRETCH_LSB +: STRETCH_W];
      if (wr_idx == IDX_INDIRECT)
        indirect_register <= hwdata_i[7:0];
      if (wr_idx == IDX_PORT2)
        port2_latch <= hwdata_i[7:0];
      if (wr_idx == IDX_DP0)
        data_pointer_zero <= hwdata_i[15:0];
      else if (inc_ptr && !ptr_sel)
        data_pointer_zero <= 16'(data_pointer_zero + 16'h0001);
      if (wr_idx == IDX_DP1)
        data_pointer_one <= hwdata_i[15:0];
      else if (inc_ptr && ptr_sel)
        data_pointer_one <= 16'(data_pointer_one + 16'h0001);
      if (cmd_accept)
        cmd <= hwdata_i;
    end
  end

  // Sequencer next state, advanced at machine cycle ends only
  always_comb
  begin
    next_fsm = fsm;
    next_mc_cnt = mc_cnt;
    next_tk = in_move ? 8'(tk + 8'h01) : 8'h00;
    case (fsm)
      ST_IDLE:
      begin
        next_mc_cnt = 4'h0;
        if (start)
          next_fsm = (cmd[CMD_OP_LSB +: CMD_OP_W] == OP_INSTR) ? ST_INSTR : ST_FETCH;
      end
      ST_INSTR:
        if (tim.mc_last)
        begin
          next_mc_cnt = 4'(mc_cnt + 4'h1);
          // Stretch never touches plain instructions
          if (4'(mc_cnt + 4'h1) == run_len)
            next_fsm = ST_IDLE;
        end
      ST_FETCH:
        if (tim.mc_last)
        begin
          next_mc_cnt = 4'(mc_cnt + 4'h1);
          next_fsm = ST_ACCESS;
        end
      ST_ACCESS:
        if (tim.mc_last)
        begin
          next_mc_cnt = 4'(mc_cnt + 4'h1);
          next_fsm = (run_stretch == '0) ? ST_IDLE : ST_STRETCH;
        end
      ST_STRETCH:
        if (tim.mc_last)
        begin
          next_mc_cnt = 4'(mc_cnt + 4'h1);
          if (4'(mc_cnt + 4'h1) == 4'(4'h2 + {1'b0, run_stretch}))
            next_fsm = ST_IDLE;
        end
      default: next_fsm = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      fsm <= ST_IDLE;
      mc_cnt <= 4'h0;
      tk <= 8'h00;
      cmd_pend <= 1'b0;
      run_op <= OP_INSTR;
      run_wr <= 1'b0;
      run_len <= MIN_INSTR_MC;
      run_data <= BYTE_RESET;
      run_stretch <= STRETCH_RESET;
      last_mc <= 4'h0;
    end
    else if (ce_i)
    begin
      fsm <= next_fsm;
      mc_cnt <= next_mc_cnt;
      tk <= next_tk;
      // Command taken at a machine cycle boundary so every move is cycle aligned
      if (cmd_accept)
        cmd_pend <= 1'b1;
      else if (start)
        cmd_pend <= 1'b0;
      if (start)
      begin
        run_op <= cmd[CMD_OP_LSB +: CMD_OP_W];
        run_wr <= cmd[CMD_WR_BIT];
        run_len <= clamp_len(cmd[CMD_LEN_LSB +: CMD_LEN_W]);
        run_data <= cmd[CMD_DATA_LSB +: 8];
        // Stretch latched at start; a later write cannot tear a running move
        run_stretch <= stretch;
      end
      if ((fsm != ST_IDLE) && (next_fsm == ST_IDLE))
        last_mc <= next_mc_cnt;
    end
  end

  // Pin sampling: accept a change once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      din_s1 <= BYTE_RESET;
      din_s2 <= BYTE_RESET;
      din_s3 <= BYTE_RESET;
      din_ok <= BYTE_RESET;
      rd_byte <= BYTE_RESET;
    end
    else if (ce_i)
    begin
      din_s1 <= ext_data_i;
      din_s2 <= din_s1;
      din_s3 <= din_s2;
      if (din_s2 == din_s3)
        din_ok <= din_s3;
      if (rd_take && !run_wr)
        rd_byte <= din_ok;
    end
  end

  // Registered pin and status outputs
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ext_addr_o <= 16'h0000;
      ext_rd_n_o <= 1'b1;
      ext_wr_n_o <= 1'b1;
      ext_data_o <= BYTE_RESET;
      ext_data_oe_o <= 1'b0;
      state_o <= 2'h0;
      opcode_fetch_o <= 1'b0;
      cpu_hold_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (in_move)
        ext_addr_o <= move_addr;
      ext_rd_n_o <= !(stb_on && !run_wr);
      ext_wr_n_o <= !(stb_on && run_wr);
      ext_data_o <= run_data;
      ext_data_oe_o <= in_move && run_wr;
      state_o <= tim.state;
      // One opcode fetch per instruction or fetch machine cycle, in state c1; none in access or stretch cycles
      opcode_fetch_o <= ((fsm == ST_INSTR) || (fsm == ST_FETCH))
        && (tim.state == state_c1) && !tim.late;
      cpu_hold_o <= (fsm == ST_STRETCH);
    end
  end

endmodule : edp_xdata_core

// *** testbench/edp_xdata_core_assertions.sv ***
// Port checks for the external data access block
`timescale 1ns/10ps
module edp_chk
  import edp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Bus
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  // Pins and timing
  input wire logic ext_rd_n_o,
  input wire logic ext_wr_n_o,
  input wire logic [1:0] state_o,
  input wire logic opcode_fetch_o,
  input wire logic cpu_hold_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [7:0] low_cnt;
  wire logic strobe_low = !ext_rd_n_o || !ext_wr_n_o;
  wire logic rd_req = hsel_i && htrans_i[1] && hready_i && ce_i && !hwrite_i;
  // Width is judged on the edge where the strobe ends
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !strobe_low)
      low_cnt <= 8'h00;
    else
      low_cnt <= low_cnt + 8'h01;
  end
  a_state_step: assert property ($changed(state_o) |-> state_o == $past(state_o) + 2'h1)
    else $error("machine state out of order");
  a_state_halves: assert property ($changed(state_o) |=> $stable(state_o))
    else $error("state shorter than two clocks");
  a_fetch_once: assert property (opcode_fetch_o |=> !opcode_fetch_o [*7])
    else $error("second fetch within a machine cycle");
  a_fetch_in_c1: assert property (opcode_fetch_o |-> state_o == 2'h0)
    else $error("fetch outside first state");
  a_strobe_len: assert property ($fell(strobe_low) |-> low_cnt == 8'h04 ||
    (low_cnt[2:0] == 3'h0 && low_cnt != 8'h00 && low_cnt <= 8'h38))
    else $error("strobe width not a legal stretch");
  a_rd_min: assert property ($fell(ext_rd_n_o) |=> !ext_rd_n_o [*3])
    else $error("read strobe too short");
  a_hold_frozen: assert property (cpu_hold_o |-> !opcode_fetch_o)
    else $error("fetch while held");
  a_read_wait: assert property (rd_req |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");
endmodule : edp_chk

bind edp_xdata_core edp_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
  .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
  .hreadyout_o(hreadyout_o), .ext_rd_n_o(ext_rd_n_o), .ext_wr_n_o(ext_wr_n_o),
  .state_o(state_o), .opcode_fetch_o(opcode_fetch_o), .cpu_hold_o(cpu_hold_o));

// *** testbench/edp_xmem.sv ***
// External data memory model with prompt or slow read answer
`timescale 1ns/10ps
module edp_xmem
(
  // Clock
  input wire logic clk_i,
  // From the device
  input wire logic [15:0] addr_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] data_i,
  input wire logic oe_i,
  input wire logic slow_i,
  // Answer and observations
  output logic [7:0] data_o,
  output logic [7:0] width_o,
  output logic [15:0] last_addr_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] cnt = 8'h00;
  logic [7:0] last_q = 8'h00;
  // Released bus toggles so a stale byte can never be mistaken for data
  assign data_o = (!rd_n_i && (!slow_i || cnt >= 8'h03)) ? mem[addr_i] : ~last_q;
  always @(posedge clk_i)
  begin
    last_q <= data_o;
    if (!wr_n_i && oe_i)
      mem[addr_i] <= data_i;
    if (!rd_n_i || !wr_n_i)
    begin
      cnt <= cnt + 8'h01;
      last_addr_o <= addr_i;
    end
    else
    begin
      if (cnt != 8'h00)
        width_o <= cnt;
      cnt <= 8'h00;
    end
  end
endmodule : edp_xmem

// *** testbench/tb_top.sv ***
// Self-checking bench for the external data access block
`timescale 1ns/10ps
module tb_top;
  import edp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic slow = 1'b0;
  logic [31:0] hrdata, rv;
  logic hready, hresp, rd_n, wr_n, oe, fetch, hold;
  logic [15:0] addr, maddr;
  logic [7:0] dout, din, mwidth;
  logic [1:0] state;
  int n_errors = 0;
  int samples_checked = 0;
  int n_fetch = 0;
  int n_hold = 0;
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    if (fetch === 1'b1) n_fetch++;
    if (hold === 1'b1) n_hold++;
  end
  edp_xdata_core u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .ext_addr_o(addr), .ext_rd_n_o(rd_n), .ext_wr_n_o(wr_n),
    .ext_data_o(dout), .ext_data_oe_o(oe), .ext_data_i(din), .state_o(state),
    .opcode_fetch_o(fetch), .cpu_hold_o(hold));
  edp_xmem u_mem (.clk_i(clk_i), .addr_i(addr), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .data_i(dout), .oe_i(oe), .slow_i(slow), .data_o(din), .width_o(mwidth),
    .last_addr_o(maddr));
  task tally_and_finish;
    begin
      if (n_errors == 0 && samples_checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask : tally_and_finish
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        n_errors++;
        $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
      end
    end
  endtask : chk
  // Level seen at the falling edge is what the next rising edge samples
  task wait_rdy(output logic [31:0] d);
    int k;
    begin
      k = 0;
      @(negedge clk_i);
      while (hready !== 1'b1 && k < 20)
      begin
        @(negedge clk_i);
        k++;
      end
      d = hrdata;
      if (k >= 20)
      begin
        chk(32'h0, 32'h1, "bus timeout");
        tally_and_finish();
      end
      @(posedge clk_i);
    end
  endtask : wait_rdy
  task bus(input logic w, input logic [IDX_W-1:0] idx, input logic [31:0] wd,
    output logic [31:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h0, idx, 2'h0};
      wait_rdy(d);
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy(d);
    end
  endtask : bus
  task wr(input logic [IDX_W-1:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    begin
      bus(1'b1, idx, wd, d);
    end
  endtask : wr
  task rd(input logic [IDX_W-1:0] idx);
    begin
      bus(1'b0, idx, 32'h0, rv);
    end
  endtask : rd
  task run(input logic [31:0] cmd);
    int k;
    begin
      n_fetch = 0;
      n_hold = 0;
      wr(IDX_CMD, cmd);
      k = 0;
      rd(IDX_STATUS);
      while ((n_fetch == 0 || rv[0] !== 1'b0) && k < 60)
      begin
        rd(IDX_STATUS);
        k++;
      end
      if (k >= 60)
      begin
        chk(32'h0, 32'h1, "move timeout");
        tally_and_finish();
      end
    end
  endtask : run
  task t_select;
    begin
      rd(IDX_PTR_SEL); chk(rv, 32'h0, "select reset");
      chk(32'(hresp), 32'h0, "bus response");
      rd(IDX_CLK_CTRL); chk(rv, 32'h1, "stretch reset");
      rd(10'h3ff); chk(rv, 32'h0, "unmapped read");
      wr(IDX_PTR_SEL, 32'hff);
      rd(IDX_PTR_SEL); chk(rv, 32'h1, "select upper bits");
      wr(IDX_CMD, 32'h3);
      rd(IDX_PTR_SEL); chk(rv, 32'h0, "toggle to zero");
      wr(IDX_CMD, 32'h3);
      rd(IDX_PTR_SEL); chk(rv, 32'h1, "toggle to one");
    end
  endtask : t_select
  // Every stretch value on a write, where strobe and hold are easy to count
  task t_sweep;
    logic [7:0] b;
    begin
      wr(IDX_DP0, 32'h1234);
      wr(IDX_PTR_SEL, 32'h0);
      for (int n = 0; n < 8; n++)
      begin
        b = 8'h50 + 8'(n);
        wr(IDX_CLK_CTRL, 32'(n));
        rd(IDX_CLK_CTRL); chk(rv, 32'(n), "stretch field");
        run({16'h0, b, 8'h0a});
        chk(32'(u_mem.mem[16'h1234]), 32'(b), "write byte");
        chk(32'(mwidth), (n == 0) ? 32'h4 : 32'(8 * n), "strobe width");
        chk(32'(n_hold), 32'(8 * n), "hold clocks");
        chk(32'(n_fetch), 32'h1, "fetch count");
        rd(IDX_STATUS); chk(32'(rv[19:16]), 32'(2 + n), "move length");
      end
    end
  endtask : t_sweep
  task t_read;
    begin
      wr(IDX_DP1, 32'habcd);
      wr(IDX_PTR_SEL, 32'h1);
      wr(IDX_CLK_CTRL, 32'h1);
      u_mem.mem[16'habcd] = 8'h96;
      run(32'h2);
      chk(32'(maddr), 32'habcd, "pointer one address");
      chk(32'(rv[15:8]), 32'h96, "pointer read byte");
      wr(IDX_CMD, 32'h4);
      rd(IDX_DP1);
      chk(rv, 32'habce, "increment selected pointer");
      rd(IDX_DP0);
      chk(rv, 32'h1234, "other pointer untouched");
      wr(IDX_CLK_CTRL, 32'h0);
      u_mem.mem[16'habce] = 8'h69;
      run(32'h2);
      chk(32'(rv[15:8]), 32'h69, "fast read byte");
      chk(32'(mwidth), 32'h4, "fast read strobe");
      wr(IDX_INDIRECT, 32'h34);
      wr(IDX_PORT2, 32'h12);
      wr(IDX_CLK_CTRL, 32'h2);
      slow <= 1'b1;
      u_mem.mem[16'h1234] = 8'hc3;
      run(32'h1);
      chk(32'(maddr), 32'h1234, "indirect address");
      chk(32'(rv[15:8]), 32'hc3, "slow read byte");
      chk(32'(mwidth), 32'h10, "read strobe width");
    end
  endtask : t_read
  // Lengths outside one to five are clamped to the nearest end
  task t_instr;
    int e;
    begin
      wr(IDX_CMD, 32'h30);
      run(32'h10);
      chk(32'(rv[19:16]), 32'h3, "busy command ignored");
      chk(32'(n_fetch), 32'h3, "busy fetch count");
      rd(IDX_CMD);
      chk(rv, 32'h30, "accepted command kept");
      for (int l = 0; l < 8; l++)
      begin
        e = (l == 0) ? 1 : ((l > 5) ? 5 : l);
        run({25'h0, 3'(l), 4'h0});
        chk(32'(rv[19:16]), 32'(e), "instr length");
        chk(32'(n_fetch), 32'(e), "one fetch per cycle");
        chk(32'(n_hold), 32'h0, "instr never held");
      end
    end
  endtask : t_instr
  // Enable low while idle must freeze the state sequence
  task t_freeze;
    logic [1:0] s;
    begin
      ce <= 1'b0;
      @(posedge clk_i);
      s = state;
      repeat (6) @(posedge clk_i);
      chk(32'(state), 32'(s), "frozen state");
      ce <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk(32'(state == s), 32'h0, "state resumes");
    end
  endtask : t_freeze
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_select;
    t_sweep;
    t_read;
    t_instr;
    t_freeze;
    tally_and_finish();
  end
endmodule : tb_top
